// File: sim/dacc_top_properties.sv
// Checker for dacc_top: register answers, enable decode, settling, hold.
// Assumes it is bound to dacc_top and sees only that module's ports.
`timescale 1ns/10ps
module dacc_top_properties #(
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic [31:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_standby,
  input wire logic [7:0]  o_analog_out_0,
  input wire logic        o_analog_out_0_oe,
  input wire logic        o_analog_out_0_valid,
  input wire logic        o_analog_out_1_oe,
  input wire logic        o_convert_0,
  input wire logic        o_convert_1
);
  localparam int SETTLE_M1 = SETTLE_CYCLES - 1;
  logic ctl_wr;
  assign ctl_wr = i_wr && (i_addr == dacc_pkg::DACC_CONTROL_OFS);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (!i_rd |=> !o_rvalid)
    else $error("read answer without read");
  chk_ctrl_ones: assert property (i_rd && i_addr == dacc_pkg::DACC_CONTROL_OFS
    |=> o_rdata[4:0] == 5'h1f) else $error("control low bits not ones");
  chk_ch0_enable: assert property (ctl_wr && !i_standby && (i_wdata[6] || i_wdata[7] && i_wdata[5])
    |=> o_analog_out_0_oe) else $error("channel 0 not enabled");
  chk_ch1_enable: assert property (ctl_wr && !i_standby && (i_wdata[7] || i_wdata[6] && i_wdata[5])
    |=> o_analog_out_1_oe) else $error("channel 1 not enabled");
  chk_both_off: assert property (ctl_wr && i_wdata[7:6] == 2'h0
    |=> !o_convert_0 && !o_convert_1) else $error("conversion left on");
  chk_ch0_alone: assert property (ctl_wr && i_wdata[7:5] == 3'h2 |=> !o_convert_1)
    else $error("channel 1 converts without enable");
  chk_settle_time: assert property ($rose(o_convert_0)
    |-> ##SETTLE_M1 !o_analog_out_0_valid ##1 o_analog_out_0_valid)
    else $error("settle time wrong");
  chk_data_restart: assert property (i_wr && i_addr == dacc_pkg::DACC_CH0_VALUE_OFS
    && o_convert_0 && !i_standby |=> !o_analog_out_0_valid) else $error("no restart");
  chk_release_hold: assert property ($fell(o_analog_out_0_oe)
    |-> !o_analog_out_0_valid && $stable(o_analog_out_0)) else $error("bad release");
  chk_standby_hold: assert property (i_standby
    |=> $stable(o_analog_out_0) && $stable(o_analog_out_0_valid)) else $error("no hold");
endmodule
bind dacc_top dacc_top_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.i_clk, .i_arst_n,
  .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rvalid, .i_standby, .o_analog_out_0,
  .o_analog_out_0_oe, .o_analog_out_0_valid, .o_analog_out_1_oe, .o_convert_0, .o_convert_1);

// File: sim/tb_top.sv
// Bench for dacc_top: register access, enable table, restart, standby hold.
// Assumes the checker file is compiled alongside; settle count shortened.
`timescale 1ns/10ps
module tb_top;
  localparam int ST = 4;
  localparam logic [31:0] CH0 = dacc_pkg::DACC_CH0_VALUE_OFS;
  localparam logic [31:0] CH1 = dacc_pkg::DACC_CH1_VALUE_OFS;
  localparam logic [31:0] CTL = dacc_pkg::DACC_CONTROL_OFS;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_standby = 1'b0;
  logic [7:0]  o_rdata, a0, a1;
  logic        o_rvalid, oe0, oe1, v0, v1;
  int          miscompares = 0;
  int          cmp_count = 0;
  dacc_top #(.SETTLE_CYCLES(ST)) dut (.i_clk, .i_arst_n, .i_addr, .i_wr, .i_rd, .i_wdata,
    .o_rdata, .o_rvalid, .i_standby, .o_analog_out_0(a0), .o_analog_out_1(a1),
    .o_analog_out_0_oe(oe0), .o_analog_out_1_oe(oe1), .o_analog_out_0_valid(v0),
    .o_analog_out_1_valid(v1), .o_convert_0(), .o_convert_1());
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    idle(1);
    i_wr = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    i_addr = a;
    i_rd = 1'b1;
    idle(1);
    cmp("rvalid", 8'h01, {7'h0, o_rvalid});
    cmp("rdata", exp, o_rdata);
    i_rd = 1'b0;
    idle(1);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_regs();
    rd(CH0, 8'h00);
    rd(CH1, 8'h00);
    rd(CTL, 8'h1f);
    cmp("enables", 8'h00, {6'h0, oe1, oe0});
    wr(CH0, 8'h5a);
    wr(CH1, 8'ha5);
    wr(32'h040000a6, 8'hff);
    wr(CTL, 8'h00);
    rd(CH0, 8'h5a);
    rd(CH1, 8'ha5);
    rd(32'h040000a6, 8'h00);
    rd(CTL, 8'h1f);
    $display("test regs done");
  endtask
  task automatic t_modes();
    logic e0, e1;
    // Every combination of the two enables and the joint bit
    for (int m = 0; m < 8; m++)
    begin
      e0 = m[1] | (m[0] & m[2]);
      e1 = m[2] | (m[0] & m[1]);
      wr(CTL, {m[2:0], 5'h00});
      idle(ST + 1);
      cmp("enables", {6'h0, e1, e0}, {6'h0, oe1, oe0});
      cmp("valid", {6'h0, e1, e0}, {6'h0, v1, v0});
      if (e0) cmp("code0", 8'h5a, a0);
      if (e1) cmp("code1", 8'ha5, a1);
      rd(CTL, {m[2:0], 5'h1f});
    end
    $display("test modes done");
  endtask
  task automatic t_restart();
    wr(CH0, 8'hc3);
    idle(1);
    cmp("restart", 8'h00, {7'h0, v0});
    idle(ST);
    cmp("code0", 8'hc3, a0);
    cmp("code1", 8'ha5, a1);
    cmp("valid", 8'h03, {6'h0, v1, v0});
    $display("test restart done");
  endtask
  task automatic t_standby();
    i_standby = 1'b1;
    idle(6);
    wr(CH0, 8'h11);
    idle(2);
    cmp("hold", 8'hc3, a0);
    cmp("valid", 8'h03, {6'h0, v1, v0});
    i_standby = 1'b0;
    wr(CTL, 8'h00);
    idle(1);
    cmp("release", 8'h00, {6'h0, oe1, oe0});
    cmp("kept", 8'hc3, a0);
    $display("test standby done");
  endtask
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    #1;
    i_arst_n = 1'b1;
    idle(1);
    t_regs();
    t_modes();
    t_restart();
    t_standby();
    give_verdict();
  end
endmodule

// File: verilog/dacc_pkg.sv
// Package for the two-channel DAC control block: register map, reset values, timing.
// Assumes a 40 MHz peripheral clock and byte accesses on the peripheral bus.
package dacc_pkg;

  // Register byte offsets within the peripheral space
  localparam logic [31:0] DACC_CH0_VALUE_OFS = 32'h040000a0;
  localparam logic [31:0] DACC_CH1_VALUE_OFS = 32'h040000a2;
  localparam logic [31:0] DACC_CONTROL_OFS   = 32'h040000a4;

  // Reset values
  localparam logic [7:0] DACC_VALUE_RST   = 8'h00;
  localparam logic [7:0] DACC_CONTROL_RST = 8'h1f;

  // Control field positions
  localparam int DACC_OE1_BIT   = 7;
  localparam int DACC_OE0_BIT   = 6;
  localparam int DACC_JOINT_BIT = 5;
  localparam logic [4:0] DACC_CTRL_LOW_ONES = 5'h1f;

  // Settling time: 10 us at 40 MHz, longest time rounds down
  localparam int DACC_SETTLE_NS      = 10000;
  localparam int DACC_CLK_PERIOD_NS  = 25;
  localparam int DACC_SETTLE_CYCLES  = DACC_SETTLE_NS / DACC_CLK_PERIOD_NS;
  localparam int DACC_CNT_W          = 9;

endpackage

// File: verilog/dacc_top.sv
// Two-channel 8-bit DAC front end: data and control registers, per-channel
// conversion timing and output drive. Assumes a byte-wide register port that
// is synchronous to i_clk, and an analog macro that turns o_analog_out_* codes
// into voltages scaled by the analog supply.
`timescale 1ns/10ps

// Operation
// - Two 8-bit read/write channel data registers, both reset to 00.
// - An enabled channel converts its data value continuously and drives its pin.
// - Control register is 8 bits and resets to 1F.
// - Bit 7 enables channel 1 conversion and output; resets to zero.
// - Bit 6 enables channel 0 conversion and output; resets to zero.
// - Joint bit clear: each channel follows its own enable bit.
// - Joint bit with any enable, or both enables, converts both channels.
// - Both enables clear disables conversion on both channels.
// - Control bits 4..0 read as one and ignore writes.
// - A write to an enabled channel's data register restarts conversion at once.
// - Output level is data over 256 times the analog supply.
// - Result is held until data is rewritten or the enable is cleared.
// - Setting an enable starts conversion and makes the pin an output.
// - Clearing an enable releases the pin to input, unless the joint bit and the other enable keep both channels converting.
// - Result becomes valid a fixed 10 us after conversion starts.
// - In standby with conversion enabled, outputs hold their values.
module dacc_top #(
  parameter int SETTLE_CYCLES = dacc_pkg::DACC_SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  // Chip standby request
  input  wire logic        i_standby,
  // Analog macro controls
  output logic [7:0]       o_analog_out_0,
  output logic [7:0]       o_analog_out_1,
  output logic             o_analog_out_0_oe,
  output logic             o_analog_out_1_oe,
  output logic             o_analog_out_0_valid,
  output logic             o_analog_out_1_valid,
  output logic             o_convert_0,
  output logic             o_convert_1
);

  initial
  begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << dacc_pkg::DACC_CNT_W))
      $error("dacc_top: SETTLE_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]                   value0;
    logic [7:0]                   value1;
    logic                         oe0;
    logic                         oe1;
    logic                         joint;
    logic                         conv0;
    logic                         conv1;
    logic [dacc_pkg::DACC_CNT_W-1:0] cnt0;
    logic [dacc_pkg::DACC_CNT_W-1:0] cnt1;
    logic                         vld0;
    logic                         vld1;
    logic [7:0]                   out0;
    logic [7:0]                   out1;
    logic [7:0]                   rdata;
    logic                         rvalid;
  } dacc_state_type;

  dacc_state_type st_q;
  dacc_state_type st_d;

  localparam logic [dacc_pkg::DACC_CNT_W-1:0] SETTLE_LAST =
    dacc_pkg::DACC_CNT_W'(SETTLE_CYCLES - 1);

  // Conversion enables from the three control bits
  function automatic logic [1:0] dacc_conv_en(input logic oe1, input logic oe0,
                                             input logic joint);
    if (!oe1 && !oe0)
      dacc_conv_en = 2'h0;
    else if ((oe1 && oe0) || joint)
      dacc_conv_en = 2'h3;
    else
      dacc_conv_en = {oe1, oe0};
  endfunction

  function automatic logic [7:0] dacc_ctrl_image(input dacc_state_type s);
    dacc_ctrl_image = {s.oe1, s.oe0, s.joint, dacc_pkg::DACC_CTRL_LOW_ONES};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       wr0;
  logic       wr1;
  logic       wrc;
  logic [1:0] en_new;

  always_comb
  begin
    st_d   = st_q;
    wr0    = i_wr && (i_addr == dacc_pkg::DACC_CH0_VALUE_OFS);
    wr1    = i_wr && (i_addr == dacc_pkg::DACC_CH1_VALUE_OFS);
    wrc    = i_wr && (i_addr == dacc_pkg::DACC_CONTROL_OFS);

    // Register writes; low control bits are not stored
    if (wr0)
      st_d.value0 = i_wdata;
    if (wr1)
      st_d.value1 = i_wdata;
    if (wrc)
    begin
      st_d.oe1   = i_wdata[dacc_pkg::DACC_OE1_BIT];
      st_d.oe0   = i_wdata[dacc_pkg::DACC_OE0_BIT];
      st_d.joint = i_wdata[dacc_pkg::DACC_JOINT_BIT];
    end
    // Decode from the incoming control value so enables act in the write cycle
    en_new = dacc_conv_en(st_d.oe1, st_d.oe0, st_d.joint);

    // Reads answer one cycle later; unmapped addresses read zero
    st_d.rvalid = i_rd;
    st_d.rdata  = 8'h00;
    if (i_rd)
    begin
      if (i_addr == dacc_pkg::DACC_CH0_VALUE_OFS)
        st_d.rdata = st_q.value0;
      else if (i_addr == dacc_pkg::DACC_CH1_VALUE_OFS)
        st_d.rdata = st_q.value1;
      else if (i_addr == dacc_pkg::DACC_CONTROL_OFS)
        st_d.rdata = dacc_ctrl_image(st_q);
    end

    // Standby freezes the conversion path, except for enable clears, so outputs hold; the level is
    // read directly so the freeze starts in the very cycle standby is seen
    if (!i_standby)
    begin
      // Channel 0
      if (!en_new[0])
      begin
        st_d.conv0 = 1'b0;
        st_d.vld0  = 1'b0;
        st_d.cnt0  = '0;
      end
      else if (!st_q.conv0)
      begin
        st_d.conv0 = 1'b1;
        st_d.cnt0  = '0;
        st_d.vld0  = 1'b0;
      end
      else if (wr0)
      begin
        st_d.cnt0 = '0;
        st_d.vld0 = 1'b0;
      end
      else if (!st_q.vld0)
      begin
        if (st_q.cnt0 == SETTLE_LAST)
        begin
          st_d.vld0 = 1'b1;
          st_d.out0 = st_q.value0;
        end
        else
          st_d.cnt0 = st_q.cnt0 + 1'b1;
      end
      // Channel 1
      if (!en_new[1])
      begin
        st_d.conv1 = 1'b0;
        st_d.vld1  = 1'b0;
        st_d.cnt1  = '0;
      end
      else if (!st_q.conv1)
      begin
        st_d.conv1 = 1'b1;
        st_d.cnt1  = '0;
        st_d.vld1  = 1'b0;
      end
      else if (wr1)
      begin
        st_d.cnt1 = '0;
        st_d.vld1 = 1'b0;
      end
      else if (!st_q.vld1)
      begin
        if (st_q.cnt1 == SETTLE_LAST)
        begin
          st_d.vld1 = 1'b1;
          st_d.out1 = st_q.value1;
        end
        else
          st_d.cnt1 = st_q.cnt1 + 1'b1;
      end
    end
    else
    begin
      // Disabling still releases pins during standby
      if (!en_new[0])
        st_d.conv0 = 1'b0;
      if (!en_new[1])
        st_d.conv1 = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q        <= '0;
      st_q.value0 <= dacc_pkg::DACC_VALUE_RST;
      st_q.value1 <= dacc_pkg::DACC_VALUE_RST;
      st_q.oe1    <= dacc_pkg::DACC_CONTROL_RST[dacc_pkg::DACC_OE1_BIT];
      st_q.oe0    <= dacc_pkg::DACC_CONTROL_RST[dacc_pkg::DACC_OE0_BIT];
      st_q.joint  <= dacc_pkg::DACC_CONTROL_RST[dacc_pkg::DACC_JOINT_BIT];
    end
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops

  always_comb
  begin
    o_rdata              = st_q.rdata;
    o_rvalid             = st_q.rvalid;
    o_analog_out_0       = st_q.out0;
    o_analog_out_1       = st_q.out1;
    o_analog_out_0_oe    = st_q.conv0;
    o_analog_out_1_oe    = st_q.conv1;
    o_analog_out_0_valid = st_q.vld0;
    o_analog_out_1_valid = st_q.vld1;
    o_convert_0          = st_q.conv0;
    o_convert_1          = st_q.conv1;
  end

endmodule
